// *** dv/sfc_host_model.sv ***
/*
 * SPI host model for the command front end, modes 0 and 3.
 * Assumes the bench resolves the shared data lines from both enables.
 */
`timescale 1ns/100ps
module sfc_host_model (
	// Host pins
	output logic      cs_n_o,
	output logic      sck_o,
	output logic      si_o,
	output logic      si_en_o,
	output logic      so_o,
	output logic      so_en_o,
	// Resolved lines
	input  wire logic si_pin_i,
	input  wire logic so_pin_i
);
	logic mode3;

	// Idle pins, frame closed
	initial begin
		mode3 = 1'b0;
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		si_o = 1'b0;
		si_en_o = 1'b0;
		so_o = 1'b0;
		so_en_o = 1'b0;
	end

	// Clock parks at the mode's idle level before select falls
	task automatic start(input logic m3);
		mode3 = m3;
		sck_o = m3;
		#40 cs_n_o = 1'b0;
		#200;
	endtask

	// Kind 0 single, 1 dual write, 2 dual read; data set on the fall
	task automatic shift(input logic [7:0] tx, input int n, input int kind,
		output logic [7:0] rx);
		rx = '0;
		for (int k = 0; k < n; k++) begin
			sck_o = 1'b0;
			si_en_o = (kind != 2);
			so_en_o = (kind == 1);
			if (kind == 0) begin
				si_o = tx[7-k];
			end else begin
				si_o = tx[6-2*k];
				so_o = tx[7-2*k];
			end
			#160 sck_o = 1'b1;
			if (kind == 0) begin
				rx[7-k] = so_pin_i;
			end else begin
				rx[7-2*k] = so_pin_i;
				rx[6-2*k] = si_pin_i;
			end
			#160;
		end
	endtask

	// Close the frame and let go of the data lines
	task automatic stop();
		if (!mode3) sck_o = 1'b0;
		#160 cs_n_o = 1'b1;
		si_en_o = 1'b0;
		so_en_o = 1'b0;
		#400;
	endtask
endmodule

// *** dv/tb_serial_flash_command_frontend.sv ***
/*
 * Bench for the command front end: host model on the pins, pushes into
 * the read buffer, expected pulses noted in a queue and checked by a monitor.
 */
`timescale 1ns/100ps
module tb_serial_flash_command_frontend;
	import sfc_pkg::*;
	logic              mclk_i;
	logic              rst_n_i;
	logic [BYTE_W-1:0] rd_byte_i;
	logic              rd_valid_i;
	wire               cs_n, sck, si_h, si_en, so_h, so_en, si_pin, so_pin;
	logic              ser_in_o, ser_in_oe_o, ser_out_o, ser_out_oe_o;
	logic              cmd_valid_o, wr_valid_o, rd_ready_o;
	sfc_cmd_t          cmd_o;
	logic [BYTE_W-1:0] wr_byte_o;
	logic [28:0]       exp_q[$];
	int                err_count = 0;
	int                n_checks = 0;
	logic [31:0]       rng = 32'h4bb4;
	logic [7:0]        rx, b0, b1;

	// Released lines show the inverse so stale values never pass
	assign si_pin = ser_in_oe_o ? ser_in_o : (si_en ? si_h : ~ser_in_o);
	assign so_pin = ser_out_oe_o ? ser_out_o : (so_en ? so_h : ~ser_out_o);

	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end

	sfc_host_model host (.cs_n_o(cs_n), .sck_o(sck), .si_o(si_h), .si_en_o(si_en),
		.so_o(so_h), .so_en_o(so_en), .si_pin_i(si_pin), .so_pin_i(so_pin));

	sfc_frontend uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sck_i(sck),
		.ser_in_i(si_pin), .ser_in_o(ser_in_o), .ser_in_oe_o(ser_in_oe_o),
		.ser_out_i(so_pin), .ser_out_o(ser_out_o), .ser_out_oe_o(ser_out_oe_o),
		.cmd_o(cmd_o), .cmd_valid_o(cmd_valid_o), .wr_byte_o(wr_byte_o),
		.wr_valid_o(wr_valid_o), .rd_byte_i(rd_byte_i), .rd_valid_i(rd_valid_i),
		.rd_ready_o(rd_ready_o));

	function automatic logic [7:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng[7:0];
	endfunction

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Each pulse takes the oldest note; a pulse with no note is a fault
	always @(negedge mclk_i) begin
		if (cmd_valid_o)
			check("cmd", {1'b1, cmd_o}, exp_q.size() ? exp_q.pop_front() : '1);
		if (wr_valid_o)
			check("wr", {21'h0, wr_byte_o}, exp_q.size() ? exp_q.pop_front() : '1);
	end

	// Opcode then address bytes, top nibble dropped in the note
	task automatic hdr(input logic [7:0] op, input logic [23:0] a, input int n);
		exp_q.push_back({1'b1, op, a[19:0]});
		host.shift(op, 8, 0, rx);
		for (int i = 0; i < n; i++) host.shift(a[23-8*i -: 8], 8, 0, rx);
	endtask

	// Offer a byte; valid stays up so pushes can run back to back
	task automatic push(input logic [7:0] v);
		int i;
		#1 rd_byte_i = v;
		rd_valid_i = 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge mclk_i);
			if (rd_ready_o) break;
		end
		// A buffer that never takes the byte is a failure
		if (i == 50) err_count++;
	endtask

	task automatic done(input string name);
		check("pending", exp_q.size(), 0);
		$display("test %s done", name);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Hang guard, well beyond the run's length
	initial begin
		#2000000;
		err_count++;
		summarize();
	end

	initial begin
		rst_n_i = 1'b0;
		rd_byte_i = '0;
		rd_valid_i = 1'b0;
		repeat (6) @(posedge mclk_i);
		#1 rst_n_i = 1'b1;
		repeat (4) @(posedge mclk_i);
		// Pins move one step after the edge, never on it
		#1;
		// Slow read: buffer fills, drains, underruns, then mid-byte abort
		host.start(1'b0);
		hdr(OP_RD_SLOW, 24'hf23456, 3);
		b0 = rnd();
		b1 = rnd();
		@(posedge mclk_i);
		push(b0);
		push(b1);
		#1 rd_valid_i = 1'b0;
		repeat (3) @(posedge mclk_i);
		#1;
		check("ready full", rd_ready_o, 0);
		host.shift(8'h00, 8, 0, rx);
		check("rd0", rx, b0);
		host.shift(8'h00, 8, 0, rx);
		check("rd1", rx, b1);
		host.shift(8'h00, 8, 0, rx);
		check("fill", rx, FILL_BYTE);
		host.shift(8'h00, 4, 0, rx);
		host.stop();
		check("released", {ser_out_oe_o, ser_in_oe_o, rd_ready_o}, 0);
		done("slow read");
		// Program in mode 3, trailing half byte dropped
		host.start(1'b1);
		hdr(OP_PROG, 24'h0abcde, 3);
		for (int i = 0; i < 2; i++) begin
			b0 = rnd();
			exp_q.push_back({21'h0, b0});
			host.shift(b0, 8, 0, rx);
		end
		host.shift(8'h5a, 4, 0, rx);
		host.stop();
		done("program");
		// Dual program then dual read
		host.start(1'b0);
		hdr(OP_PROG_DUAL, 24'h100001, 3);
		b0 = rnd();
		exp_q.push_back({21'h0, b0});
		host.shift(b0, 4, 1, rx);
		host.stop();
		host.start(1'b1);
		hdr(OP_RD_DUAL, 24'h0fffff, 3);
		host.shift(8'h00, 8, 0, rx);
		b0 = rnd();
		@(posedge mclk_i);
		push(b0);
		#1 rd_valid_i = 1'b0;
		host.shift(8'h00, 4, 2, rx);
		check("dual rd", rx, b0);
		host.stop();
		done("dual");
		// Unknown opcode, trailing bytes ignored, next frame clean
		host.start(1'b0);
		host.shift(8'hff, 8, 0, rx);
		for (int i = 0; i < 3; i++) host.shift(OP_RD_SLOW, 8, 0, rx);
		host.stop();
		host.start(1'b0);
		hdr(OP_WEN, 24'h0, 0);
		host.stop();
		done("unknown op");
		// Short header and five-bit opcode do nothing
		host.start(1'b0);
		host.shift(OP_ERS_4K, 8, 0, rx);
		host.shift(8'h12, 8, 0, rx);
		host.shift(8'h34, 8, 0, rx);
		host.stop();
		host.start(1'b0);
		host.shift(OP_ERS_4K, 5, 0, rx);
		host.stop();
		host.start(1'b0);
		hdr(OP_ERS_4K, 24'h012345, 3);
		host.stop();
		done("abort");
		// Mode 3 read with two dummy bytes; early or late data shows up
		host.start(1'b1);
		hdr(OP_RD_MAX, 24'h3c0a5f, 3);
		b0 = rnd();
		@(posedge mclk_i);
		push(b0);
		#1 rd_valid_i = 1'b0;
		for (int i = 0; i < 2; i++) host.shift(8'h00, 8, 0, rx);
		host.shift(8'h00, 8, 0, rx);
		check("dummy rd", rx, b0);
		host.stop();
		done("fast read");
		summarize();
	end
endmodule

// *** logic/sfc_frontend.sv ***
/*
 * Serial flash command front end: frames SPI transactions by chip select,
 * parses opcode, address and dummy bytes, passes program data out and
 * shifts read data in from a small buffer. Assumes the array side runs
 * on mclk_i and that SCK is at least eight mclk periods long.
 */
// Behaviour
// - Only SPI modes 0 and 3 are served, the idle clock level is irrelevant.
// - Input bits are taken on SCK rising edges and output bits change on falling edges.
// - During dual-input program the serial output pin is read as a second input.
// - During dual-output read the serial input pin is driven as a second output.
// - Every byte moves most significant bit first in both directions.
// - An unsupported opcode starts no operation.
// - After an unsupported opcode all input is ignored until the next frame.
// - A frame cut short before opcode and address are complete does nothing.
// - The top four received address bits are dropped, twenty bits are kept.
// - Raising chip select ends a read and releases the output at once.
`timescale 1ns/100ps
module sfc_frontend
	import sfc_pkg::*;
#(
	parameter int RD_DEPTH = 2
) (
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	// Serial pins
	input  wire logic        cs_n_i,
	input  wire logic        sck_i,
	input  wire logic        ser_in_i,
	output logic             ser_in_o,
	output logic             ser_in_oe_o,
	input  wire logic        ser_out_i,
	output logic             ser_out_o,
	output logic             ser_out_oe_o,
	// Decoded command
	output sfc_cmd_t         cmd_o,
	output logic             cmd_valid_o,
	// Program data bytes
	output logic [BYTE_W-1:0] wr_byte_o,
	output logic             wr_valid_o,
	// Read data bytes
	input  wire logic [BYTE_W-1:0] rd_byte_i,
	input  wire logic        rd_valid_i,
	output logic             rd_ready_o
);

	localparam int PW = $clog2(RD_DEPTH);

	// The pointer logic wraps naturally, so the depth must be a power of two
	generate
		if (RD_DEPTH < 2 || (1 << PW) != RD_DEPTH) begin : g_bad_depth
			$error("RD_DEPTH must be a power of two of at least 2");
		end
	endgenerate

	// Two-stage synchronisers plus one history stage for the clock
	logic [3:0] sync1_q, sync2_q;
	logic       sck_old_q;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_q   <= 4'hf;
			sync2_q   <= 4'hf;
			sck_old_q <= 1'b1; // Matches synced reset level, no false rising edge
		end else begin
			sync1_q   <= {cs_n_i, sck_i, ser_in_i, ser_out_i};
			sync2_q   <= sync1_q;
			sck_old_q <= sync2_q[2];
		end
	end

	// Edges are taken from the second stage only; idle level does not matter
	wire cs_act   = ~sync2_q[3];
	wire sck_rise = sync2_q[2] & ~sck_old_q;
	wire sck_fall = ~sync2_q[2] & sck_old_q;
	wire si_s     = sync2_q[1];
	wire so_s     = sync2_q[0];

	// Parser state
	sfc_state_t        state_q, state_d;
	sfc_opc_info_t     info_q, info_d;
	logic [BYTE_W-1:0] opc_q, opc_d;
	logic [ADDR_HW-1:0] addr_q, addr_d;
	logic [1:0]        idx_q, idx_d, dummy_q, dummy_d;
	logic [BYTE_W-1:0] rx_sh_q;
	logic [2:0]        rx_cnt_q;
	sfc_cmd_t          cmd_d;
	logic              cmd_valid_d, wr_valid_d;

	// Receive shifter decode; dual input packs two bits per edge
	wire               dual_rx  = (state_q == SFC_DIN) && info_q.dual_in;
	wire [2:0]         rx_step  = dual_rx ? STEP_DUAL : STEP_SGL;
	wire [2:0]         rx_nx    = rx_cnt_q + rx_step;
	wire [BYTE_W-1:0]  rx_byte  = dual_rx ? {rx_sh_q[5:0], so_s, si_s}
	                                      : {rx_sh_q[6:0], si_s};
	wire               rx_done  = sck_rise && (rx_nx == 3'h0);
	wire sfc_opc_info_t dec     = sfc_decode(rx_byte);
	wire [ARRAY_AW-1:0] full_addr = {addr_q[11:0], rx_byte};

	// Next state of the frame parser
	always_comb begin
		state_d     = state_q;
		info_d      = info_q;
		opc_d       = opc_q;
		addr_d      = addr_q;
		idx_d       = idx_q;
		dummy_d     = dummy_q;
		cmd_d       = cmd_o;
		cmd_valid_d = 1'b0;
		wr_valid_d  = 1'b0;
		case (state_q)
			SFC_IDLE: if (cs_act) state_d = SFC_OPC;
			SFC_OPC: if (rx_done) begin
				opc_d  = rx_byte;
				info_d = dec;
				idx_d  = 2'h0;
				if (!dec.ok) begin
					state_d = SFC_IGNORE;
				end else if (dec.has_addr) begin
					state_d = SFC_ADDR;
				end else begin
					cmd_d       = '{opcode: rx_byte, addr: '0};
					cmd_valid_d = 1'b1;
					state_d     = dec.out_phase ? SFC_DOUT : SFC_DIN;
				end
			end
			SFC_ADDR: if (rx_done) begin
				addr_d = {addr_q[7:0], rx_byte};
				idx_d  = idx_q + 2'h1;
				if (idx_q == ADDR_LAST) begin
					cmd_d       = '{opcode: opc_q, addr: full_addr};
					cmd_valid_d = 1'b1;
					dummy_d     = info_q.dummy;
					if (info_q.dummy != DUMMY_NONE) state_d = SFC_DUMMY;
					else state_d = info_q.out_phase ? SFC_DOUT : SFC_DIN;
				end
			end
			SFC_DUMMY: if (rx_done) begin
				dummy_d = dummy_q - 2'h1;
				if (dummy_q == DUMMY_ONE) state_d = SFC_DOUT;
			end
			SFC_DIN: wr_valid_d = rx_done;
			SFC_DOUT, SFC_IGNORE: state_d = state_q;
			default: state_d = SFC_IDLE;
		endcase
		if (!cs_act) begin
			state_d     = SFC_IDLE;
			cmd_valid_d = 1'b0;
			wr_valid_d  = 1'b0;
		end
	end

	// Parser registers; the bit counter rx_cnt_q is held at zero outside a frame
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q     <= SFC_IDLE;
			info_q      <= '0;
			opc_q       <= '0;
			addr_q      <= '0;
			idx_q       <= 2'h0;
			dummy_q     <= 2'h0;
			rx_sh_q     <= '0;
			rx_cnt_q    <= 3'h0;
			cmd_o       <= '0;
			cmd_valid_o <= 1'b0;
			wr_byte_o   <= '0;
			wr_valid_o  <= 1'b0;
		end else begin
			state_q     <= state_d;
			info_q      <= info_d;
			opc_q       <= opc_d;
			addr_q      <= addr_d;
			idx_q       <= idx_d;
			dummy_q     <= dummy_d;
			cmd_o       <= cmd_d;
			cmd_valid_o <= cmd_valid_d;
			wr_valid_o  <= wr_valid_d;
			if (wr_valid_d) wr_byte_o <= rx_byte;
			if (!cs_act) rx_cnt_q <= 3'h0;
			else if (sck_rise) rx_cnt_q <= rx_nx;
			if (cs_act && sck_rise) rx_sh_q <= rx_byte;
		end
	end

	// Read buffer; flushed between frames so no stale byte leaks out
	logic [BYTE_W-1:0] mem_q [RD_DEPTH];
	logic [PW-1:0]     wp_q, rp_q;
	logic [PW:0]       cnt_q;
	logic [2:0]        tx_left_q;
	logic [BYTE_W-1:0] tx_sh_q;
	wire               push    = rd_valid_i && rd_ready_o;
	wire               tx_load = sck_fall && (state_q == SFC_DOUT) && (tx_left_q == 3'h0);
	wire               pop     = tx_load && (cnt_q != '0);
	wire [PW:0]        cnt_d   = cnt_q + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
	wire [BYTE_W-1:0]  tx_src  = (tx_left_q != 3'h0) ? tx_sh_q
	                           : ((cnt_q != '0) ? mem_q[rp_q] : FILL_BYTE);
	wire               dual_tx = info_q.dual_out;
	wire               drive   = cs_act && (state_q == SFC_DOUT);

	always_ff @(posedge mclk_i) begin
		if (push) mem_q[wp_q] <= rd_byte_i;
	end

	// Buffer pointers and the transmit shifter
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wp_q         <= '0;
			rp_q         <= '0;
			cnt_q        <= '0;
			rd_ready_o   <= 1'b0;
			tx_left_q    <= 3'h0;
			tx_sh_q      <= '0;
			ser_out_o    <= 1'b0;
			ser_in_o     <= 1'b0;
			ser_out_oe_o <= 1'b0;
			ser_in_oe_o  <= 1'b0;
		end else begin
			if (!cs_act) begin
				rp_q  <= wp_q;
				cnt_q <= '0;
			end else begin
				if (push) wp_q <= wp_q + 1'b1;
				if (pop) rp_q <= rp_q + 1'b1;
				cnt_q <= cnt_d;
			end
			rd_ready_o <= cs_act && (cnt_d < (PW+1)'(RD_DEPTH));
			if (!drive) begin
				tx_left_q <= 3'h0;
			end else if (sck_fall) begin
				ser_out_o <= tx_src[7];
				ser_in_o  <= tx_src[6];
				tx_sh_q   <= dual_tx ? {tx_src[5:0], 2'b00} : {tx_src[6:0], 1'b0};
				if (tx_load) tx_left_q <= dual_tx ? TX_DUAL : TX_SGL;
				else tx_left_q <= tx_left_q - 3'h1;
			end
			ser_out_oe_o <= drive && (sck_fall || ser_out_oe_o);
			ser_in_oe_o  <= drive && dual_tx && (sck_fall || ser_in_oe_o);
		end
	end

	// Checks on the parser and pin drivers
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	a_release_on_end: assert property (!cs_act |=> !ser_out_oe_o && !ser_in_oe_o)
		else $error("output still driven after chip select rose");
	a_out_on_fall: assert property ($changed(ser_out_o) |-> $past(sck_fall))
		else $error("serial output changed away from a falling edge");
	a_in_on_rise: assert property ($changed(rx_sh_q) |-> $past(sck_rise && cs_act))
		else $error("receive shifter moved without a rising edge");
	a_bad_opcode: assert property (state_q == SFC_OPC && rx_done && cs_act && !dec.ok
		|=> state_q == SFC_IGNORE ##1 !cmd_valid_o)
		else $error("unsupported opcode was not refused");
	a_ignore_hold: assert property (state_q == SFC_IGNORE && cs_act |=> state_q == SFC_IGNORE
		&& !wr_valid_o && !cmd_valid_o)
		else $error("input was acted on after an unsupported opcode");
	a_cmd_in_frame: assert property (cmd_valid_o |-> $past(cs_act)
		&& ($past(state_q) inside {SFC_OPC, SFC_ADDR}))
		else $error("command issued without a complete header");
	a_addr_low20: assert property (cmd_valid_o && $past(state_q) == SFC_ADDR
		|-> cmd_o.addr == {$past(addr_q[11:0]), $past(rx_byte)})
		else $error("address not cut to twenty bits");
	a_frame_start: assert property ($rose(cs_act) |=> rx_cnt_q == 3'h0 && state_q == SFC_OPC)
		else $error("new frame did not clear the counters");
	a_msb_first: assert property (state_q == SFC_DIN && !info_q.dual_in && rx_done && cs_act
		|=> wr_byte_o[0] == $past(si_s) && wr_byte_o[7:1] == $past(rx_sh_q[6:0]))
		else $error("received byte not assembled msb first");
	a_dual_in: assert property (dual_rx && sck_rise && cs_act
		|=> rx_sh_q[1:0] == {$past(so_s), $past(si_s)})
		else $error("dual input did not take both lines");
	a_dual_out_only: assert property (ser_in_oe_o |-> info_q.dual_out
		&& state_q == SFC_DOUT)
		else $error("serial input pin driven outside dual read");

endmodule

// *** logic/sfc_pkg.sv ***
/*
 * Shared constants, opcode table and carrier types of the serial flash
 * command front end. Assumes a single system clock domain in the user.
 */
package sfc_pkg;

	// Widths of the serial word and the array address
	localparam int BYTE_W   = 8;
	localparam int ARRAY_AW = 20;
	localparam int ADDR_HW  = 16;

	// Byte counts of the framing
	localparam logic [1:0] ADDR_LAST = 2'h2;
	localparam logic [1:0] DUMMY_NONE = 2'h0;
	localparam logic [1:0] DUMMY_ONE  = 2'h1;
	localparam logic [1:0] DUMMY_TWO  = 2'h2;

	// Steps of the bit counter and its reload values
	localparam logic [2:0] STEP_SGL  = 3'h1;
	localparam logic [2:0] STEP_DUAL = 3'h2;
	localparam logic [2:0] TX_SGL    = 3'h7;
	localparam logic [2:0] TX_DUAL   = 3'h3;

	// Byte shifted out when the read buffer has run dry
	localparam logic [7:0] FILL_BYTE = 8'hff;

	// Supported opcodes
	localparam logic [7:0] OP_RD_MAX = 8'h1b, OP_RD_FAST = 8'h0b, OP_RD_SLOW = 8'h03;
	localparam logic [7:0] OP_RD_DUAL = 8'h3b, OP_ERS_4K = 8'h20, OP_ERS_32K = 8'h52;
	localparam logic [7:0] OP_ERS_64K = 8'hd8, OP_ERS_CHA = 8'h60, OP_ERS_CHB = 8'hc7;
	localparam logic [7:0] OP_PROG = 8'h02, OP_PROG_DUAL = 8'ha2, OP_WEN = 8'h06;
	localparam logic [7:0] OP_WDIS = 8'h04, OP_PROT = 8'h36, OP_UNPROT = 8'h39;
	localparam logic [7:0] OP_RD_PROT = 8'h3c, OP_LOCK = 8'h33, OP_FREEZE = 8'h34;
	localparam logic [7:0] OP_RD_LOCK = 8'h35, OP_OTP_PROG = 8'h9b, OP_OTP_RD = 8'h77;
	localparam logic [7:0] OP_RD_STAT = 8'h05, OP_WR_STAT1 = 8'h01, OP_WR_STAT2 = 8'h31;
	localparam logic [7:0] OP_RESET = 8'hf0, OP_RD_ID = 8'h9f, OP_DPD = 8'hb9;
	localparam logic [7:0] OP_DPD_EXIT = 8'hab;

	// Parser states, Gray along idle, opcode, address, dummy, data
	typedef enum logic [2:0] {
		SFC_IDLE   = 3'h0,
		SFC_OPC    = 3'h1,
		SFC_ADDR   = 3'h3,
		SFC_DUMMY  = 3'h2,
		SFC_DIN    = 3'h6,
		SFC_DOUT   = 3'h7,
		SFC_IGNORE = 3'h5
	} sfc_state_t;

	// What an opcode asks of the parser
	typedef struct packed {
		logic       ok;
		logic       has_addr;
		logic [1:0] dummy;
		logic       out_phase;
		logic       dual_in;
		logic       dual_out;
	} sfc_opc_info_t;

	// Command handed to the array side
	typedef struct packed {
		logic [BYTE_W-1:0]   opcode;
		logic [ARRAY_AW-1:0] addr;
	} sfc_cmd_t;

	// Opcode table lookup
	function automatic sfc_opc_info_t sfc_decode(input logic [7:0] op);
		sfc_opc_info_t i;
		i = '0;
		i.ok = 1'b1;
		case (op)
			OP_RD_MAX, OP_OTP_RD: begin
				i.has_addr = 1'b1; i.dummy = DUMMY_TWO; i.out_phase = 1'b1;
			end
			OP_RD_FAST: begin
				i.has_addr = 1'b1; i.dummy = DUMMY_ONE; i.out_phase = 1'b1;
			end
			OP_RD_DUAL: begin
				i.has_addr = 1'b1; i.dummy = DUMMY_ONE; i.out_phase = 1'b1;
				i.dual_out = 1'b1;
			end
			OP_RD_SLOW, OP_RD_PROT, OP_RD_LOCK: begin
				i.has_addr = 1'b1; i.out_phase = 1'b1;
			end
			OP_PROG_DUAL: begin
				i.has_addr = 1'b1; i.dual_in = 1'b1;
			end
			OP_ERS_4K, OP_ERS_32K, OP_ERS_64K, OP_PROG, OP_PROT, OP_UNPROT,
			OP_LOCK, OP_FREEZE, OP_OTP_PROG: i.has_addr = 1'b1;
			OP_RD_STAT, OP_RD_ID: i.out_phase = 1'b1;
			OP_ERS_CHA, OP_ERS_CHB, OP_WEN, OP_WDIS, OP_WR_STAT1, OP_WR_STAT2,
			OP_RESET, OP_DPD, OP_DPD_EXIT: i.ok = 1'b1;
			default: i.ok = 1'b0;
		endcase
		return i;
	endfunction

endpackage
